// ==== tspt_map.svh ====
// register map, field positions and reset values of the periodic timer
// assumes an 8-bit byte address on the AXI4-Lite slave
`ifndef TSPT_MAP_SVH
`define TSPT_MAP_SVH
`define TSPT_OFF_CTL   8'h00
`define TSPT_OFF_CNT   8'h04
`define TSPT_OFF_PER   8'h08
`define TSPT_OFF_STS   8'h0c
`define TSPT_OFF_MSK   8'h10
`define TSPT_RESV_HI   15
`define TSPT_RESV_LO   12
`define TSPT_SOFT      11
`define TSPT_FREE      10
`define TSPT_PRE_HI    9
`define TSPT_PRE_LO    6
`define TSPT_RELOAD    5
`define TSPT_STOP      4
`define TSPT_DIV_HI    3
`define TSPT_DIV_LO    0
`define TSPT_CNT_RST   16'hffff
`define TSPT_PER_RST   16'hffff
`define TSPT_DIV_RST   4'h0
`define TSPT_PRE_RST   4'h0
`define TSPT_BIT_RST   1'h0
`define TSPT_RESP_OK   2'h0
`define TSPT_RESP_ERR  2'h2
`define TSPT_STS_WRAP  0
`endif

// ==== tspt_pkg.sv ====
// types shared by the periodic timer modules
// assumes nothing of its surroundings
package tspt_pkg;
   typedef logic [15:0] tspt_word_t;
   typedef logic [3:0]  tspt_nib_t;
   typedef enum logic [1:0] {
      TSPT_HALT_NOW,
      TSPT_HALT_AT_ZERO,
      TSPT_HALT_FREE
   } tspt_halt_mode_t;
endpackage : tspt_pkg

// ==== tspt_stage.sv ====
// one reloadable down-counter stage of the periodic timer
// assumes a single clock and a synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module tspt_stage #(
   parameter int           W       = 16,
   parameter logic [W-1:0] RST_VAL = '1
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   input  wire logic         tick,
   input  wire logic [W-1:0] reload_val,
   output var  logic [W-1:0] count_q,
   output var  logic         borrow
);
   logic [W-1:0] count_d;
   wire          at_zero = (count_q == '0);

   // the borrow leaves with the reload, on the first tick after zero is reached
   assign borrow  = tick && at_zero && !load;
   assign count_d = load   ? load_val   :
                    borrow ? reload_val :
                    tick   ? count_q - {{(W-1){1'h0}}, 1'h1} :
                             count_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) count_q <= RST_VAL;
      else          count_q <= count_d;
   end
endmodule : tspt_stage
`default_nettype wire

// ==== tspt_timer.sv ====
// two-stage periodic timer with an AXI4-Lite register slave
// assumes one clock aclk and a synchronous active-low reset aresetn
//
// Behaviour
// - control bits 15..12 are reserved and always read as zero.
// - on halt with run-through clear, stop-at-zero picks stop now or at zero.
// - with run-through set the timer keeps counting through a halt.
// - prescale count bits 9..6 reload from divide-down on borrow.
// - writing reload bit 5 loads main from period, prescale from divide-down.
// - the reload bit always reads back as zero.
// - stop bit 4 halts counting when set; clear at reset so timer runs.
// - divide-down bits 3..0 hold prescale period, reset to zero.
// - main count reloads from period at zero or on reload command.
// - each stage borrows and reloads on its first tick after reaching zero.
// - the main borrow is a one-cycle interrupt and output pin pulse unless period and divide-down are both zero.
// - interrupt rate is clock over (divide-down+1) times (period+1).
// - main count and control reads return the live counts.
// - while running the prescale count drops by one every cycle until zero, then reloads.
// - while stopped the counters hold still, saving power.
// - reset sets main count and period to all ones.
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "tspt_map.svh"
module tspt_timer (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        halt_req,
   output var  logic        timer_irq,
   output var  logic        timer_out_pin,
   output var  logic        irq
);
   // ****************************************************************
   // bus slave state
   // ****************************************************************
   logic        aw_have_q, w_have_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0]  bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic        rd_ctl_q;

   wire aw_hs = s_axi_awvalid && awready_q;
   wire w_hs  = s_axi_wvalid && wready_q;
   wire ar_hs = s_axi_arvalid && arready_q;
   wire wr_fire = aw_have_q && w_have_q && !bvalid_q;

   wire wr_ctl = wr_fire && (awaddr_q == `TSPT_OFF_CTL);
   wire wr_cnt = wr_fire && (awaddr_q == `TSPT_OFF_CNT);
   wire wr_per = wr_fire && (awaddr_q == `TSPT_OFF_PER);
   wire wr_sts = wr_fire && (awaddr_q == `TSPT_OFF_STS);
   wire wr_msk = wr_fire && (awaddr_q == `TSPT_OFF_MSK);
   wire wr_ok  = wr_ctl || wr_cnt || wr_per || wr_sts || wr_msk;

   // ****************************************************************
   // timer state
   // ****************************************************************
   logic              soft_q, free_q, stop_q, soft_done_q;
   tspt_pkg::tspt_nib_t  div_q, pre_cnt;
   tspt_pkg::tspt_word_t per_q, cnt;
   logic              sts_q, msk_q;
   logic              irq_pulse_q, pin_q, irq_q;
   logic              pre_borrow, cnt_borrow;

   // byte lanes 0 and 1 carry the 16-bit registers
   wire [15:0] old_ctl = {4'h0, soft_q, free_q, pre_cnt, 1'h0, stop_q,
                          div_q};
   wire [15:0] lane_m  = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   wire [15:0] new_ctl = (wdata_q[15:0] & lane_m) | (old_ctl & ~lane_m);
   wire [15:0] new_cnt = (wdata_q[15:0] & lane_m) | (cnt & ~lane_m);
   wire [15:0] new_per = (wdata_q[15:0] & lane_m) | (per_q & ~lane_m);

   wire reload = wr_ctl && new_ctl[`TSPT_RELOAD];

   tspt_pkg::tspt_halt_mode_t halt_mode;
   assign halt_mode = free_q ? tspt_pkg::TSPT_HALT_FREE :
                      soft_q ? tspt_pkg::TSPT_HALT_AT_ZERO :
                               tspt_pkg::TSPT_HALT_NOW;
   wire halt_block = halt_req &&
        ((halt_mode == tspt_pkg::TSPT_HALT_NOW) ||
         ((halt_mode == tspt_pkg::TSPT_HALT_AT_ZERO) && soft_done_q));
   wire count_en = !stop_q && !halt_block;

   // ****************************************************************
   // counting stages
   // ****************************************************************
   // a stopped timer feeds no tick, so neither stage toggles
   tspt_stage #(.W(4), .RST_VAL(`TSPT_PRE_RST)) u_prescale (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .load       (reload),
      .load_val   (new_ctl[`TSPT_DIV_HI:`TSPT_DIV_LO]),
      .tick       (count_en),
      .reload_val (div_q),
      .count_q    (pre_cnt),
      .borrow     (pre_borrow)
   );

   tspt_stage #(.W(16), .RST_VAL(`TSPT_CNT_RST)) u_main (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .load       (reload || wr_cnt),
      .load_val   (wr_cnt ? new_cnt : per_q),
      .tick       (pre_borrow),
      .reload_val (per_q),
      .count_q    (cnt),
      .borrow     (cnt_borrow)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         soft_q <= `TSPT_BIT_RST;
         free_q <= `TSPT_BIT_RST;
         stop_q <= `TSPT_BIT_RST;
         div_q  <= `TSPT_DIV_RST;
      end else if (wr_ctl) begin
         soft_q <= new_ctl[`TSPT_SOFT];
         free_q <= new_ctl[`TSPT_FREE];
         stop_q <= new_ctl[`TSPT_STOP];
         div_q  <= new_ctl[`TSPT_DIV_HI:`TSPT_DIV_LO];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)    per_q <= `TSPT_PER_RST;
      else if (wr_per) per_q <= new_per;
   end

   // stop-at-zero: let the halt bite once the main count wraps
   always_ff @(posedge aclk) begin
      if (!aresetn || !halt_req) soft_done_q <= `TSPT_BIT_RST;
      else if (cnt_borrow && halt_mode == tspt_pkg::TSPT_HALT_AT_ZERO)
         soft_done_q <= 1'h1;
   end

   // ****************************************************************
   // interrupt pulse and sticky status
   // ****************************************************************
   wire sts_clr = wr_sts && wstrb_q[0] && wdata_q[`TSPT_STS_WRAP];
   // a wrap in the clearing cycle wins over the clear
   wire sts_d = cnt_borrow || (sts_q && !sts_clr);
   wire msk_d = wr_msk && wstrb_q[0] ? wdata_q[`TSPT_STS_WRAP] : msk_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_pulse_q <= `TSPT_BIT_RST;
         pin_q       <= `TSPT_BIT_RST;
         sts_q       <= `TSPT_BIT_RST;
         msk_q       <= `TSPT_BIT_RST;
         irq_q       <= `TSPT_BIT_RST;
      end else begin
         irq_pulse_q <= cnt_borrow;
         pin_q       <= cnt_borrow;
         sts_q       <= sts_d;
         msk_q       <= msk_d;
         irq_q       <= sts_d && msk_d;
      end
   end

   // ****************************************************************
   // AXI4-Lite write channel
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'h0;
         w_have_q  <= 1'h0;
         awready_q <= 1'h0;
         wready_q  <= 1'h0;
         bvalid_q  <= 1'h0;
         bresp_q   <= `TSPT_RESP_OK;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
      end else begin
         awready_q <= s_axi_awvalid && !awready_q && !aw_have_q;
         wready_q  <= s_axi_wvalid && !wready_q && !w_have_q;
         if (aw_hs) begin
            aw_have_q <= 1'h1;
            awaddr_q  <= {s_axi_awaddr[7:2], 2'h0};
         end
         if (w_hs) begin
            w_have_q <= 1'h1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_have_q <= 1'h0;
            w_have_q  <= 1'h0;
            bvalid_q  <= 1'h1;
            bresp_q   <= wr_ok ? `TSPT_RESP_OK : `TSPT_RESP_ERR;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'h0;
         end
      end
   end

   // ****************************************************************
   // AXI4-Lite read channel
   // ****************************************************************
   wire [7:0]  ra     = {s_axi_araddr[7:2], 2'h0};
   // reserved bits and the reload bit are never stored, so read zero
   wire [15:0] rd_ctl = {4'h0, soft_q, free_q, pre_cnt,
                         1'h0, stop_q, div_q};
   wire        rd_ok  = (ra == `TSPT_OFF_CTL) || (ra == `TSPT_OFF_CNT) ||
                        (ra == `TSPT_OFF_PER) || (ra == `TSPT_OFF_STS) ||
                        (ra == `TSPT_OFF_MSK);
   wire [15:0] rd_val = (ra == `TSPT_OFF_CTL) ? rd_ctl :
                        (ra == `TSPT_OFF_CNT) ? cnt :
                        (ra == `TSPT_OFF_PER) ? per_q :
                        (ra == `TSPT_OFF_STS) ? {15'h0000, sts_q} :
                        (ra == `TSPT_OFF_MSK) ? {15'h0000, msk_q} :
                                                16'h0000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'h0;
         rvalid_q  <= 1'h0;
         rresp_q   <= `TSPT_RESP_OK;
         rdata_q   <= 32'h0000_0000;
         rd_ctl_q  <= 1'h0;
      end else begin
         arready_q <= s_axi_arvalid && !arready_q && !rvalid_q;
         if (ar_hs) begin
            rvalid_q <= 1'h1;
            rdata_q  <= {16'h0000, rd_val};
            rresp_q  <= rd_ok ? `TSPT_RESP_OK : `TSPT_RESP_ERR;
            rd_ctl_q <= (ra == `TSPT_OFF_CTL);
         end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'h0;
         end
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
   assign timer_irq     = irq_pulse_q;
   assign timer_out_pin = pin_q;
   assign irq           = irq_q;

   // ****************************************************************
   // checks
   // ****************************************************************
   a_resv_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      rvalid_q && rd_ctl_q |-> rdata_q[`TSPT_RESV_HI:`TSPT_RESV_LO] == 4'h0)
      else $error("reserved control bits read nonzero");

   a_strobe_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(rvalid_q) && rd_ctl_q |-> !rdata_q[`TSPT_RELOAD])
      else $error("reload bit read back as one");

   a_halt_now: assert property (@(posedge aclk) disable iff (!aresetn)
      halt_req && !free_q && !soft_q && !wr_fire |=> $stable(pre_cnt))
      else $error("prescaler moved during immediate halt");

   a_free_run: assert property (@(posedge aclk) disable iff (!aresetn)
      halt_req && free_q && !stop_q && !wr_fire && pre_cnt != 4'h0
      |=> pre_cnt == $past(pre_cnt) - 4'h1)
      else $error("prescaler stalled in run-through mode");

   a_pre_reload: assert property (@(posedge aclk) disable iff (!aresetn)
      count_en && pre_cnt == 4'h0 && !wr_fire |=> pre_cnt == $past(div_q))
      else $error("prescaler did not reload from divide-down");

   a_strobe_load: assert property (@(posedge aclk) disable iff (!aresetn)
      reload |=> cnt == $past(per_q) &&
                 pre_cnt == $past(new_ctl[`TSPT_DIV_HI:`TSPT_DIV_LO]))
      else $error("reload did not load both counters");

   a_stop_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      stop_q && !wr_fire |=> $stable(cnt) && $stable(pre_cnt))
      else $error("counters moved while stopped");

   a_main_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
      pre_borrow && cnt == 16'h0000 && !wr_fire
      |=> cnt == $past(per_q) && timer_irq && timer_out_pin)
      else $error("main count did not wrap with a pulse");

   a_pulse_one: assert property (@(posedge aclk) disable iff (!aresetn)
      timer_irq && (per_q != 16'h0000 || div_q != 4'h0) && !wr_fire
      |=> !timer_irq)
      else $error("interrupt pulse wider than one cycle");
endmodule : tspt_timer
`default_nettype wire

// ==== tspt_cpu_model.sv ====
// cpu-side model of the timer: AXI4-Lite master, one access at a time
// assumes the slave answers every request; the bench bounds each wait
`timescale 1ns/10ps
`default_nettype none
module tspt_cpu_model (
   input  wire logic        aclk,
   output var  logic [7:0]  s_axi_awaddr,
   output var  logic        s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output var  logic [31:0] s_axi_wdata,
   output var  logic [3:0]  s_axi_wstrb,
   output var  logic        s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic        s_axi_bvalid,
   output var  logic        s_axi_bready,
   output var  logic [7:0]  s_axi_araddr,
   output var  logic        s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic        s_axi_rvalid,
   output var  logic        s_axi_rready
);
   // ****************************************
   // bus cycles
   // ****************************************
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
   end
   // released payload is inverted so a stale value is never taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr  <= ~a;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata  <= ~d;
         end
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr  <= ~a;
         end
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask : rd
endmodule : tspt_cpu_model
`default_nettype wire

// ==== tb.sv ====
// self-checking bench of the periodic timer, cpu model on the bus
// assumes the timer and cpu model files are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "tspt_map.svh"
module tb;
   logic        aclk, aresetn, halt_req, timer_irq, timer_out_pin, irq;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, prev;
   logic [3:0]  dd;
   logic [15:0] per;
   logic [65:0] note;
   logic [65:0] rq[$];
   logic [1:0]  wq[$];
   int          gq[$];
   int          num_errors, num_checks, gap, npulse, n0, g;
   localparam logic [7:0] CT = `TSPT_OFF_CTL;
   localparam logic [7:0] CN = `TSPT_OFF_CNT;
   localparam logic [7:0] PR = `TSPT_OFF_PER;
   localparam logic [7:0] ST = `TSPT_OFF_STS;
   localparam logic [7:0] MS = `TSPT_OFF_MSK;
   localparam logic [1:0] OK = `TSPT_RESP_OK;
   localparam logic [1:0] ER = `TSPT_RESP_ERR;
   tspt_timer i_tspt_timer (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .halt_req, .timer_irq,
      .timer_out_pin, .irq);
   tspt_cpu_model i_tspt_cpu_model (.aclk, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);
   // ****************************************
   // helpers
   // ****************************************
   task automatic bad(input string m);
      num_errors++;
      $display("BAD %0t %s", $time, m);
   endtask : bad
   task automatic close_out;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : close_out
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      wq.push_back(r);
      i_tspt_cpu_model.wr(a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m, input logic [1:0] r);
      rq.push_back({r, m, e});
      i_tspt_cpu_model.rd(a);
   endtask : rd
   function automatic logic [31:0] cw(input logic s, f, r, t);
      return {20'h0, s, f, 4'h0, r, t, dd};
   endfunction : cw
   task automatic wait_pulse;
      int i;
      i = 0;
      do begin
         @(posedge aclk);
         i++;
      end while (timer_irq !== 1'b1 && i < 5000);
      if (i >= 5000) bad("no timer pulse");
   endtask : wait_pulse
   task automatic irq_is(input logic v);
      repeat (2) @(posedge aclk);
      num_checks++;
      if (irq !== v) bad("irq level");
   endtask : irq_is
   // ****************************************
   // clock, monitor, watchdog
   // ****************************************
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   // gap counts edges since the last pulse; a gq entry is a full period
   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready) begin
         note = rq.pop_front();
         num_checks++;
         if (((s_axi_rdata ^ note[31:0]) & note[63:32]) !== 32'h0 ||
             s_axi_rresp !== note[65:64]) bad("read data or resp");
      end
      if (s_axi_bvalid && s_axi_bready) begin
         num_checks++;
         if (s_axi_bresp !== wq.pop_front()) bad("write resp");
      end
      if (aresetn && timer_out_pin !== timer_irq) bad("pin differs");
      if (timer_irq === 1'b1) begin
         npulse++;
         num_checks++;
         if (prev === 1'b1) bad("pulse too wide");
         if (gq.size() > 0) begin
            num_checks++;
            if (gap !== gq.pop_front()) bad("pulse period");
         end
         gap = 1;
      end else
         gap++;
      prev = timer_irq;
   end
   initial begin
      repeat (40000) @(posedge aclk);
      bad("timeout");
      close_out();
   end
   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      {aresetn, halt_req, prev} = '0;
      {num_errors, num_checks, gap, npulse} = '0;
      void'($urandom(32'had6c));
      dd = 4'($urandom % 16);
      per = 16'($urandom % 8 + 2);
      g = (dd + 1) * (per + 1);
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd(CT, 32'h0, '1, OK);
      rd(PR, 32'hffff, '1, OK);
      rd(CN, 32'hff00, 32'hffffff00, OK);
      repeat (2) wr(CT, 32'h10, OK);
      wr(CN, 32'h1234, OK);
      rd(CN, 32'h1234, '1, OK);
      wr(PR, {16'h0, per}, OK);
      rd(PR, {16'h0, per}, '1, OK);
      wr(8'h14, 32'h1, ER);
      rd(8'h14, 32'h0, '1, ER);
      wr(CT, 32'hf000 | cw(0, 0, 1, 1), OK);
      rd(CT, {20'h0, 2'h0, dd, 2'h1, dd}, '1, OK);
      rd(CN, {16'h0, per}, '1, OK);
      wr(MS, 32'h1, OK);
      for (int k = 0; k < 4; k++) begin
         wr(CT, cw(k[0], k[1], 1, 0), OK);
         wait_pulse();
         @(posedge aclk);
         gq.push_back(g);
         wait_pulse();
         halt_req <= 1'b1;
         repeat (2) @(posedge aclk);
         @(negedge aclk);
         n0 = npulse;
         repeat (3 * g) @(negedge aclk);
         num_checks++;
         if (npulse - n0 != (k[1] ? 3 : k[0] ? 1 : 0)) bad("halt");
         @(posedge aclk);
         halt_req <= 1'b0;
      end
      repeat (2) wr(CT, cw(0, 0, 0, 1), OK);
      @(negedge aclk);
      n0 = npulse;
      repeat (3 * g) @(negedge aclk);
      num_checks++;
      if (npulse != n0) bad("stopped timer pulsed");
      rd(ST, 32'h1, '1, OK);
      irq_is(1'b1);
      wr(MS, 32'h0, OK);
      irq_is(1'b0);
      wr(MS, 32'h1, OK);
      irq_is(1'b1);
      wr(ST, 32'h1, OK);
      rd(ST, 32'h0, '1, OK);
      irq_is(1'b0);
      repeat (4) @(posedge aclk);
      close_out();
   end
endmodule : tb
`default_nettype wire
